/* logic/gpio_bank_pkg.sv */
// Shared constants and types for the general purpose pin bank.
// Assumes a single 250 MHz clock; used by the bank module and its bench.
package gpio_bank_pkg;

	// Clock rate and indicator timing
	localparam int unsigned CLK_HZ       = 250_000_000;
	localparam int unsigned LED_ON_MS    = 1000;
	localparam int unsigned LED_OFF_MS   = 2000;
	localparam int unsigned LED_ON_CYC   = CLK_HZ / 1000 * LED_ON_MS;
	localparam int unsigned LED_OFF_CYC  = CLK_HZ / 1000 * LED_OFF_MS;
	localparam int unsigned PULSE_MS     = 1000;

	// Bank size and indicator pin
	localparam int unsigned NUM_PINS     = 10;
	localparam int unsigned LED_PIN      = 0;

	// Command argument values enabling the indicator (pin 1, value 0, mode 2)
	localparam logic [3:0] LED_CMD_PIN   = 4'h1;
	localparam logic       LED_CMD_VAL   = 1'h0;

	// Pin modes written by the configuration command
	typedef enum logic [1:0] {
		MODE_IN  = 2'b00,
		MODE_OUT = 2'b01,
		MODE_ALT = 2'b10
	} pin_mode_t;

	// Reset values: input with pull-down
	localparam pin_mode_t MODE_RST       = MODE_IN;
	localparam logic      PULL_DOWN_RST  = 1'h1;
	localparam logic      OUT_VAL_RST    = 1'h0;

	// Network status seen by the indicator
	typedef enum logic [2:0] {
		NET_OFF        = 3'b000,
		NET_UNREG      = 3'b001,
		NET_IDLE       = 3'b010,
		NET_IDLE_SAVE  = 3'b011,
		NET_CONNECTING = 3'b100
	} net_state_t;

	// Configuration command, one-cycle strobe with its arguments
	typedef struct packed {
		logic       valid;
		logic       write;  // 1 configures, 0 queries
		logic [3:0] pin;    // 1..10 as numbered on the package
		logic       value;  // output level for output mode
		pin_mode_t  mode;
	} pin_cmd_t;

	// Answer to a query
	typedef struct packed {
		logic      valid;
		logic      level;
		pin_mode_t mode;
	} pin_rsp_t;

endpackage

/* logic/gpio_bank.sv */
// Ten-pin configurable bank with a network status indicator on pin one.
// Assumes commands and network status come from logic on clk_i; pads are
// asynchronous and are synchronised before use.
//
// Behaviour
// - Input read returns sampled pad level; writes ignored
// - Output write drives level; query returns programmed value
// - Alternate function pin driven only by internal logic
// - Ten pins, reset to input with pull-down
// - Output mode drives both levels push-pull
// - Command 1,0,2 routes indicator onto pin one
// - Off, on unregistered, idle blinks 1s/2s
// - Connecting blinks one second on, two off
// - Power saving idle pulses only on paging wake-ups
`timescale 1ns/100ps
module gpio_bank
	import gpio_bank_pkg::*;
#(
	parameter int unsigned PINS    = NUM_PINS,
	parameter int unsigned ON_CYC  = LED_ON_CYC,
	parameter int unsigned OFF_CYC = LED_OFF_CYC
) (
	// Clock, reset and enable
	input  wire logic            clk_i,
	input  wire logic            resetn_i,
	input  wire logic            ce_i,
	// Configuration command channel
	input  wire pin_cmd_t        cmd_i,
	output pin_rsp_t             rsp_o,
	// Network status from the modem firmware
	input  wire net_state_t      net_i,
	input  wire logic            wake_i,
	// Pads
	input  wire logic [PINS-1:0] pad_i,
	output logic      [PINS-1:0] pad_o,
	output logic      [PINS-1:0] pad_oe_o,
	output logic      [PINS-1:0] pull_down_o
);

	localparam int unsigned PER_CYC = ON_CYC + OFF_CYC;
	localparam int unsigned CW      = $clog2(PER_CYC + 1);

	pin_mode_t         mode_r [PINS];
	logic [PINS-1:0]   out_r;
	logic [PINS-1:0]   sync1_r;
	logic [PINS-1:0]   sync2_r;
	logic [CW-1:0]     blink_r;
	logic [CW-1:0]     pulse_r;
	logic              led_r;
	logic              led_nxt;
	logic [3:0]        idx;
	logic              cmd_ok;

	assign idx    = cmd_i.pin - 4'h1;
	assign cmd_ok = cmd_i.valid && cmd_i.pin != 4'h0
		&& cmd_i.pin <= 4'(PINS);

	// Two-flop pad synchroniser; first stage read only by the second
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else if (ce_i) begin
			sync1_r <= pad_i;
			sync2_r <= sync1_r;
		end
	end

	// Per-pin configuration; only the addressed pin changes
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < PINS; i++) begin
				mode_r[i] <= MODE_RST;
			end
			out_r <= {PINS{OUT_VAL_RST}};
		end else if (ce_i && cmd_ok && cmd_i.write) begin
			mode_r[idx] <= cmd_i.mode;
			// Output value only latched in output mode
			if (cmd_i.mode == MODE_OUT) begin
				out_r[idx] <= cmd_i.value;
			end
		end
	end

	// Query answer; input pins report the synchronised pad level
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rsp_o <= '0;
		end else if (ce_i) begin
			rsp_o.valid <= cmd_ok && !cmd_i.write;
			rsp_o.mode  <= cmd_ok ? mode_r[idx] : MODE_IN;
			case (cmd_ok ? mode_r[idx] : MODE_IN)
				MODE_OUT: rsp_o.level <= out_r[idx];
				MODE_ALT: rsp_o.level <= pad_o[idx];
				default:  rsp_o.level <= cmd_ok && sync2_r[idx];
			endcase
		end
	end

	// Free-running 3 s blink period; period counter restarts after off
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			blink_r <= '0;
		end else if (ce_i) begin
			if (blink_r >= CW'(PER_CYC - 1)) begin
				blink_r <= '0;
			end else begin
				blink_r <= blink_r + CW'(1);
			end
		end
	end

	// Wake pulse timer, one on-time long, started by paging wake-ups
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pulse_r <= '0;
		end else if (ce_i) begin
			if (wake_i && net_i == NET_IDLE_SAVE) begin
				pulse_r <= CW'(ON_CYC);
			end else if (pulse_r != '0) begin
				pulse_r <= pulse_r - CW'(1);
			end
		end
	end

	// Indicator pattern per network state
	always_comb begin
		case (net_i)
			NET_OFF:        led_nxt = 1'b0;
			NET_UNREG:      led_nxt = 1'b1;
			NET_IDLE:       led_nxt = blink_r < CW'(ON_CYC);
			NET_CONNECTING: led_nxt = blink_r < CW'(ON_CYC);
			NET_IDLE_SAVE:  led_nxt = pulse_r != '0;
			default:        led_nxt = 1'b0;
		endcase
	end

	// Registered indicator level keeps pad data glitch free
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			led_r <= 1'b0;
		end else if (ce_i) begin
			led_r <= led_nxt;
		end
	end

	// Pad drive: push-pull in output mode, internal logic in alternate
	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			pull_down_o[i] = mode_r[i] == MODE_IN ? PULL_DOWN_RST : 1'b0;
			case (mode_r[i])
				MODE_OUT: begin
					pad_oe_o[i] = 1'b1;
					pad_o[i]    = out_r[i];
				end
				MODE_ALT: begin
					// Only pin one has an alternate source
					pad_oe_o[i] = i == LED_PIN;
					pad_o[i]    = i == LED_PIN && led_r;
				end
				default: begin
					pad_oe_o[i] = 1'b0;
					pad_o[i]    = 1'b0;
				end
			endcase
		end
	end

	// Assertions, all on clk_i and quiet during reset

	// Pin one carries the indicator while alternate
	AST_ALT_LED: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		mode_r[LED_PIN] == MODE_ALT |-> pad_oe_o[LED_PIN]
		&& pad_o[LED_PIN] == led_r)
		else $error("indicator not routed to pin one");

	// User write to the alternate pin leaves level and value alone
	AST_ALT_NOWRITE: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		ce_i && cmd_ok && cmd_i.write && idx == 4'(LED_PIN)
		&& cmd_i.mode == MODE_ALT && mode_r[LED_PIN] == MODE_ALT
		|=> pad_o[LED_PIN] == $past(led_nxt)
		&& $stable(out_r[LED_PIN]))
		else $error("user write overrode alternate pin");

	// Output write is driven on the next cycle
	AST_OUT_DRIVE: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		ce_i && cmd_ok && cmd_i.write && cmd_i.mode == MODE_OUT |=>
		pad_oe_o[$past(idx)] && pad_o[$past(idx)] == $past(cmd_i.value))
		else $error("output write not driven");

	// Pin two as input releases its driver and keeps the pull-down
	AST_IN_HIZ: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		mode_r[1] == MODE_IN |-> !pad_oe_o[1] && pull_down_o[1])
		else $error("input pin driven or pull-down missing");

	// Input query answers with the synchronised level
	AST_IN_READ: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		ce_i && cmd_ok && !cmd_i.write && mode_r[idx] == MODE_IN |=>
		rsp_o.valid && rsp_o.level == $past(sync2_r[idx]))
		else $error("input read wrong level");

	// Dark while the device is off
	AST_OFF: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		ce_i && net_i == NET_OFF |=> !led_r)
		else $error("indicator lit while off");

	// Steady on while searching for a network
	AST_UNREG: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		ce_i && net_i == NET_UNREG |=> led_r)
		else $error("indicator dark while unregistered");

	// On-time ends when the blink counter reaches ON_CYC
	AST_BLINK: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		ce_i && net_i == NET_CONNECTING && blink_r == CW'(ON_CYC) |=>
		!led_r)
		else $error("blink on-time too long");

	// Power saving stays dark between wake-ups
	AST_WAKE: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		ce_i && net_i == NET_IDLE_SAVE && pulse_r == '0 && !wake_i |=>
		!led_r)
		else $error("indicator lit without wake-up");

	// Writes to other pins leave pin three untouched
	AST_ISOLATE: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		ce_i && cmd_ok && cmd_i.write && idx != 4'h2 |=>
		$stable(mode_r[2]))
		else $error("other pin disturbed");

endmodule

/* test/pad_model.sv */
// Far-side pads: external drivers plus the device's own drive.
// Assumes one external driver per pin, enabled by the bench.
`timescale 1ns/100ps
module pad_model #(
	parameter int unsigned PINS = 10
) (
	// Clock
	input  wire logic            clk_i,
	// Device side of the pads
	input  wire logic [PINS-1:0] drv_i,
	input  wire logic [PINS-1:0] oe_i,
	input  wire logic [PINS-1:0] pd_i,
	// External devices
	input  wire logic [PINS-1:0] ext_en_i,
	input  wire logic [PINS-1:0] ext_val_i,
	// Resolved pad levels
	output logic      [PINS-1:0] lvl_o
);
	logic [PINS-1:0] float_r = '0;

	// Floating pads wander, so a stale level never reads as valid
	always_ff @(posedge clk_i) begin
		float_r <= ~float_r;
	end

	// Device drive wins, then external drive, then pull-down
	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			if (oe_i[i]) begin
				lvl_o[i] = drv_i[i];
			end else if (ext_en_i[i]) begin
				lvl_o[i] = ext_val_i[i];
			end else if (pd_i[i]) begin
				lvl_o[i] = 1'b0;
			end else begin
				lvl_o[i] = float_r[i];
			end
		end
	end
endmodule

/* test/tb_top.sv */
// Self-checking bench for the pin bank and its status indicator.
// Assumes short indicator timing parameters for simulation speed.
`timescale 1ns/100ps
module tb_top;
	import gpio_bank_pkg::*;
	localparam int unsigned ON  = 10;
	localparam int unsigned OFF = 20;
	logic       clk_i = 0, resetn_i = 0, ce_i = 1, wake_i = 0;
	pin_cmd_t   cmd_i = '0;
	net_state_t net_i = NET_OFF;
	pin_rsp_t   rsp_o;
	logic [9:0] pad_i, pad_o, pad_oe_o, pull_down_o;
	logic [9:0] ext_en = '0, ext_val = '0;
	int         err_count = 0, num_checks = 0, n;

	// 250 MHz clock
	always #2 clk_i = ~clk_i;

	gpio_bank #(.PINS(10), .ON_CYC(ON), .OFF_CYC(OFF)) dut_u (
		.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .cmd_i(cmd_i),
		.rsp_o(rsp_o), .net_i(net_i), .wake_i(wake_i), .pad_i(pad_i),
		.pad_o(pad_o), .pad_oe_o(pad_oe_o), .pull_down_o(pull_down_o));
	pad_model #(.PINS(10)) pads_u (
		.clk_i(clk_i), .drv_i(pad_o), .oe_i(pad_oe_o), .pd_i(pull_down_o),
		.ext_en_i(ext_en), .ext_val_i(ext_val), .lvl_o(pad_i));

	task chk(string what, logic [9:0] exp, logic [9:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One command, then settle to the middle of the answer cycle
	task send(logic w, logic [3:0] p, logic v, pin_mode_t m);
		@(posedge clk_i) cmd_i <= {1'b1, w, p, v, m};
		@(posedge clk_i) cmd_i <= '0;
		@(negedge clk_i);
	endtask

	// Lit cycles of the indicator over one whole blink period
	task lit(output int c);
		c = 0;
		repeat (ON + OFF) begin
			@(negedge clk_i);
			if (pad_o[0] === 1'b1) c++;
		end
	endtask

	task t_pins;
		chk("reset oe", 10'h000, pad_oe_o);
		chk("reset pull", 10'h3FF, pull_down_o);
		@(posedge clk_i) {ext_en, ext_val} <= {10'h004, 10'h004};
		repeat (3) @(posedge clk_i);
		send(0, 4'h3, 0, MODE_IN);
		chk("in level", 10'h001, 10'(rsp_o.level));
		chk("in valid", 10'h001, 10'(rsp_o.valid));
		send(0, 4'h4, 0, MODE_IN);
		chk("in low", 10'h000, 10'(rsp_o.level));
		send(1, 4'h3, 1, MODE_IN);
		chk("in oe", 10'h000, pad_oe_o);
		send(1, 4'h5, 1, MODE_OUT);
		chk("out oe", 10'h010, pad_oe_o);
		chk("out pull", 10'h3EF, pull_down_o);
		chk("out lvl", 10'h001, 10'(pad_o[4]));
		send(0, 4'h5, 0, MODE_IN);
		chk("out query", 10'h001, 10'(rsp_o.level));
		chk("out mode", 10'(MODE_OUT), 10'(rsp_o.mode));
		// Clock enable low: a write must not land
		@(posedge clk_i) ce_i <= 0;
		send(1, 4'h6, 1, MODE_OUT);
		chk("frozen oe", 10'h010, pad_oe_o);
		@(posedge clk_i) ce_i <= 1;
		// Pin number out of range is refused
		send(1, 4'hB, 1, MODE_OUT);
		chk("bad pin oe", 10'h010, pad_oe_o);
		$display("pin test done");
	endtask

	task t_led;
		send(1, LED_CMD_PIN, LED_CMD_VAL, MODE_ALT);
		chk("alt oe", 10'h011, pad_oe_o);
		chk("led off", 10'h000, 10'(pad_o[0]));
		send(1, 4'h1, 1, MODE_ALT);
		chk("alt write", 10'h000, 10'(pad_o[0]));
		@(posedge clk_i) net_i <= NET_UNREG;
		repeat (3) @(negedge clk_i);
		chk("led unreg", 10'h001, 10'(pad_o[0]));
		@(posedge clk_i) net_i <= NET_IDLE;
		repeat (2) @(posedge clk_i);
		lit(n);
		chk("idle lit", 10'(ON), 10'(n));
		@(posedge clk_i) net_i <= NET_CONNECTING;
		repeat (2) @(posedge clk_i);
		lit(n);
		chk("conn lit", 10'(ON), 10'(n));
		@(posedge clk_i) net_i <= NET_IDLE_SAVE;
		repeat (3) @(posedge clk_i);
		lit(n);
		chk("save quiet", 10'h000, 10'(n));
		@(posedge clk_i) wake_i <= 1;
		@(posedge clk_i) wake_i <= 0;
		lit(n);
		chk("save wake", 10'(ON), 10'(n));
		$display("indicator test done");
	endtask

	task finish_test;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Reset for six cycles, then the scenarios
	initial begin
		repeat (6) @(posedge clk_i);
		resetn_i <= 1;
		@(negedge clk_i);
		t_pins();
		t_led();
		finish_test();
	end
endmodule
